// file: design/ptmr_defs.svh
// constants for the periodic timer block: offsets, field positions, resets
// assumes inclusion by bare name; holds definitions only
`ifndef PTMR_DEFS_SVH
`define PTMR_DEFS_SVH
`define PTMR_OFF_CTRL0 12'h000
`define PTMR_OFF_CTRL1 12'h004
`define PTMR_OFF_DUTY 12'h008
`define PTMR_OFF_PERIOD 12'h00c
`define PTMR_OFF_STATUS 12'h010
`define PTMR_OFF_COUNT 12'h014
`define PTMR_CTRL0_EN_BIT 3
`define PTMR_C1_MODE_HI 7
`define PTMR_C1_MODE_LO 6
`define PTMR_C1_PIN_HI 5
`define PTMR_C1_PIN_LO 4
`define PTMR_C1_ACT_BIT 3
`define PTMR_C1_INV_BIT 2
`define PTMR_C1_CSRC_BIT 1
`define PTMR_C1_CCLR_BIT 0
`define PTMR_ST_A_BIT 0
`define PTMR_ST_P_BIT 1
`define PTMR_RST_CTRL1 8'h00
`define PTMR_RST_CMP 10'h000
`endif

// file: design/ptmr_pkg.sv
// types shared by the periodic timer block
// assumes ptmr_defs.svh is compiled alongside
package ptmr_pkg;
  typedef enum logic [1:0] {
    PTMR_MODE_CMP = 2'b00,
    PTMR_MODE_CAP = 2'b01,
    PTMR_MODE_PWM = 2'b10,
    PTMR_MODE_TMR = 2'b11
  } ptmr_mode_t;
  typedef enum logic [1:0] {
    PTMR_AXI_OKAY = 2'b00,
    PTMR_AXI_SLVERR = 2'b10
  } ptmr_resp_t;
endpackage

// file: design/ptmr_sync.sv
// three-stage synchroniser for the two timer input pins
// assumes the pins are asynchronous to aclk
`timescale 1ns/100ps
module ptmr_sync #(
  parameter int WIDTH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] fall_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // a change counts once stage two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_reg[i] <= 1'b0;
          s2_reg[i] <= 1'b0;
          s3_reg[i] <= 1'b0;
          level_out[i] <= 1'b0;
        end else begin
          s1_reg[i] <= pin_in[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          if (s2_reg[i] == s3_reg[i]) begin
            level_out[i] <= s3_reg[i];
          end
        end
      end
      assign rise_out[i] = (s2_reg[i] == s3_reg[i]) & s3_reg[i] &
                           ~level_out[i];
      assign fall_out[i] = (s2_reg[i] == s3_reg[i]) & ~s3_reg[i] &
                           level_out[i];
    end
  endgenerate
endmodule

// file: design/ptmr_top.sv
// periodic timer: compare, timer, pwm, single pulse and capture modes
// assumes an AXI4-Lite master and a one-cycle timer clock enable
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "ptmr_defs.svh"
module ptmr_top #(
  parameter int CW = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick_en,
  input wire logic capture_input_pin,
  input wire logic clock_trigger_pin,
  output logic waveform_output_pin,
  output logic waveform_output_oe,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // control state
  logic timer_enable_bit_reg;
  logic en_prev_reg;
  logic [7:0] timer_control_one_reg;
  logic [CW-1:0] duty_capture_compare_reg;
  logic [CW-1:0] period_compare_reg;
  logic [CW-1:0] count_reg;
  logic comparator_a_flag_reg;
  logic comparator_p_flag_reg;
  logic pin_level_reg;
  // bus state
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // field decode
  wire [1:0] mode_code = timer_control_one_reg[`PTMR_C1_MODE_HI:
                                               `PTMR_C1_MODE_LO];
  wire [1:0] pin_function_field = timer_control_one_reg[`PTMR_C1_PIN_HI:
                                                        `PTMR_C1_PIN_LO];
  wire active_level_bit = timer_control_one_reg[`PTMR_C1_ACT_BIT];
  wire pin_inversion_bit = timer_control_one_reg[`PTMR_C1_INV_BIT];
  wire capture_source_bit = timer_control_one_reg[`PTMR_C1_CSRC_BIT];
  wire clear_select_bit = timer_control_one_reg[`PTMR_C1_CCLR_BIT];
  wire is_cmp = (mode_code == ptmr_pkg::PTMR_MODE_CMP);
  wire is_tmr = (mode_code == ptmr_pkg::PTMR_MODE_TMR);
  wire is_cap = (mode_code == ptmr_pkg::PTMR_MODE_CAP);
  wire is_pw = (mode_code == ptmr_pkg::PTMR_MODE_PWM);
  wire is_pulse = is_pw & (pin_function_field == 2'b11);
  wire is_pwm = is_pw & ~is_pulse;

  // pin synchroniser and edge detection
  wire [1:0] pin_level;
  wire [1:0] pin_rise;
  wire [1:0] pin_fall;
  ptmr_sync #(
    .WIDTH(2)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({clock_trigger_pin, capture_input_pin}),
    .level_out(pin_level),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  // capture source and edge selection; pin direction is irrelevant
  wire cap_rise = capture_source_bit ? pin_rise[1] : pin_rise[0];
  wire cap_fall = capture_source_bit ? pin_fall[1] : pin_fall[0];
  wire cap_edge = (pin_function_field == 2'b00) ? cap_rise :
                  (pin_function_field == 2'b01) ? cap_fall :
                  (pin_function_field == 2'b10) ? (cap_rise | cap_fall) :
                  1'b0;
  wire cap_hit = is_cap & timer_enable_bit_reg & tick_en & cap_edge;
  // trigger pin sets enable in single pulse mode (rising edge taken)
  wire trig_hit = is_pulse & ~timer_enable_bit_reg & pin_rise[1];

  // comparators; period 0 matches at full wrap
  wire running = timer_enable_bit_reg & en_prev_reg;
  wire match_a = running & tick_en & (count_reg == duty_capture_compare_reg);
  wire p_zero = (period_compare_reg == '0);
  // match one count early so a period of p spans exactly p counts;
  // p = 0 wraps to all-ones and gives the full 2**CW count cycle
  wire [CW-1:0] p_last = period_compare_reg - 1'b1;
  wire match_p = running & tick_en & (count_reg == p_last);
  // which matches clear the counter in each mode
  wire clr_a = (is_cmp | is_tmr) & clear_select_bit;
  wire clr_p = ((is_cmp | is_tmr) & ~clear_select_bit) |
               is_pwm | is_cap;
  wire set_a = match_a & ~is_cap;
  wire set_p = match_p & ~is_pulse & ~clr_a;
  wire cap_p_flag = match_p & is_cap;

  // pulse end: A match clears enable
  wire pulse_end = is_pulse & match_a;

  // pwm waveform: active while count below duty
  wire duty_full = (duty_capture_compare_reg >= period_compare_reg) &
                   ~p_zero;
  wire pwm_active = duty_full | (count_reg < duty_capture_compare_reg);
  wire pwm_raw = (pin_function_field == 2'b00) ? 1'b0 :
                 (pin_function_field == 2'b01) ? 1'b1 :
                 (pin_function_field == 2'b10) ? pwm_active :
                 timer_enable_bit_reg;
  wire pwm_level = (pwm_raw ? active_level_bit : ~active_level_bit) ^
                   pin_inversion_bit;

  // compare output action on A flag
  wire [1:0] pf = pin_function_field;
  wire cmp_next = (pf == 2'b01) ? 1'b0 :
                  (pf == 2'b10) ? 1'b1 :
                  (pf == 2'b11) ? ~pin_level_reg : pin_level_reg;
  wire en_rise = timer_enable_bit_reg & ~en_prev_reg;

  // bus write decode
  wire wr_go = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  wire wr_ctrl0 = wr_go & (awaddr_reg == `PTMR_OFF_CTRL0) & wstrb_reg[0];
  wire wr_ctrl1 = wr_go & (awaddr_reg == `PTMR_OFF_CTRL1) & wstrb_reg[0];
  wire wr_duty = wr_go & (awaddr_reg == `PTMR_OFF_DUTY);
  wire wr_per = wr_go & (awaddr_reg == `PTMR_OFF_PERIOD);
  wire wr_stat = wr_go & (awaddr_reg == `PTMR_OFF_STATUS) & wstrb_reg[0];
  wire wr_ok = (awaddr_reg == `PTMR_OFF_CTRL0) |
               (awaddr_reg == `PTMR_OFF_CTRL1) |
               (awaddr_reg == `PTMR_OFF_DUTY) |
               (awaddr_reg == `PTMR_OFF_PERIOD) |
               (awaddr_reg == `PTMR_OFF_STATUS);
  wire [CW-1:0] wval = wdata_reg[CW-1:0];
  wire [CW-1:0] wmasked_duty = {
    wstrb_reg[1] ? wval[CW-1:8] : duty_capture_compare_reg[CW-1:8],
    wstrb_reg[0] ? wval[7:0] : duty_capture_compare_reg[7:0]};
  wire [CW-1:0] wmasked_per = {
    wstrb_reg[1] ? wval[CW-1:8] : period_compare_reg[CW-1:8],
    wstrb_reg[0] ? wval[7:0] : period_compare_reg[7:0]};

  // enable bit: software, trigger pin, and pulse end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_enable_bit_reg <= 1'b0;
      en_prev_reg <= 1'b0;
    end else begin
      en_prev_reg <= timer_enable_bit_reg;
      if (pulse_end) begin
        timer_enable_bit_reg <= 1'b0;
      end else if (wr_ctrl0) begin
        timer_enable_bit_reg <= wdata_reg[`PTMR_CTRL0_EN_BIT];
      end else if (trig_hit) begin
        timer_enable_bit_reg <= 1'b1;
      end
    end
  end

  // counter: zero on enable rise, hold while off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
    end else if (en_rise) begin
      count_reg <= '0;
    end else if (running & tick_en) begin
      if ((match_a & clr_a) | (match_p & clr_p)) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  // control, compare and capture registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control_one_reg <= `PTMR_RST_CTRL1;
      duty_capture_compare_reg <= `PTMR_RST_CMP;
      period_compare_reg <= `PTMR_RST_CMP;
    end else begin
      if (wr_ctrl1) begin
        timer_control_one_reg <= wdata_reg[7:0];
      end
      // hardware capture wins over a software write
      if (cap_hit) begin
        duty_capture_compare_reg <= count_reg;
      end else if (wr_duty) begin
        duty_capture_compare_reg <= wmasked_duty;
      end
      if (wr_per) begin
        period_compare_reg <= wmasked_per;
      end
    end
  end

  // sticky flags; set beats a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comparator_a_flag_reg <= 1'b0;
      comparator_p_flag_reg <= 1'b0;
    end else begin
      comparator_a_flag_reg <= (set_a | cap_hit) | (comparator_a_flag_reg &
        ~(wr_stat & wdata_reg[`PTMR_ST_A_BIT]));
      comparator_p_flag_reg <= (set_p | cap_p_flag) | (comparator_p_flag_reg &
        ~(wr_stat & wdata_reg[`PTMR_ST_P_BIT]));
    end
  end

  // compare-mode pin level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_level_reg <= 1'b0;
    end else if (is_cmp & en_rise) begin
      pin_level_reg <= active_level_bit;
    end else if (is_cmp & set_a) begin
      pin_level_reg <= cmp_next;
    end
  end

  // output pin driver; timer mode and capture release the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waveform_output_pin <= 1'b0;
      waveform_output_oe <= 1'b0;
    end else begin
      waveform_output_oe <= is_cmp | is_pw;
      if (is_pw) begin
        waveform_output_pin <= pwm_level;
      end else begin
        waveform_output_pin <= pin_level_reg ^ pin_inversion_bit;
      end
    end
  end

  // write channel capture; address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ptmr_pkg::PTMR_AXI_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? ptmr_pkg::PTMR_AXI_OKAY :
                               ptmr_pkg::PTMR_AXI_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ready while nothing is held for that channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_hold_reg & ~(s_axi_awvalid & s_axi_awready) &
                       ~s_axi_bvalid;
      s_axi_wready <= ~w_hold_reg & ~(s_axi_wvalid & s_axi_wready) &
                      ~s_axi_bvalid;
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
    end
  end

  // read decode
  wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
  wire [31:0] rd_ctrl0 = {28'h0000000, timer_enable_bit_reg, 3'b000};
  wire [31:0] rd_stat = {30'h00000000, comparator_p_flag_reg,
                         comparator_a_flag_reg};
  wire [31:0] rd_data =
    (ra == `PTMR_OFF_CTRL0) ? rd_ctrl0 :
    (ra == `PTMR_OFF_CTRL1) ? {24'h000000, timer_control_one_reg} :
    (ra == `PTMR_OFF_DUTY) ? {{(32-CW){1'b0}}, duty_capture_compare_reg} :
    (ra == `PTMR_OFF_PERIOD) ? {{(32-CW){1'b0}}, period_compare_reg} :
    (ra == `PTMR_OFF_STATUS) ? rd_stat :
    (ra == `PTMR_OFF_COUNT) ? {{(32-CW){1'b0}}, count_reg} : 32'h00000000;
  wire rd_ok = (ra <= `PTMR_OFF_COUNT);

  // read response, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= ptmr_pkg::PTMR_AXI_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? ptmr_pkg::PTMR_AXI_OKAY :
                             ptmr_pkg::PTMR_AXI_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// file: verification/ptmr_checker.sv
// port-level assertions for the periodic timer: bus handshakes, output pin
// assumes it is bound onto ptmr_top and sees only that module's ports
`timescale 1ns/100ps
module ptmr_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick_en,
  input wire logic clock_trigger_pin,
  input wire logic waveform_output_pin,
  input wire logic waveform_output_oe,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] quiet_reg;
  logic trig_reg;
  // cycles since anything that could move the pin; trigger sync is slow
  always_ff @(posedge aclk) begin
    trig_reg <= clock_trigger_pin;
    if (!aresetn || tick_en || s_axi_wvalid || clock_trigger_pin != trig_reg)
    begin
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hf) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer; s_wr_both |-> ##[1:2] s_axi_bvalid; endproperty
  property p_rd_answer; s_rd_taken |-> ##[1:2] s_axi_rvalid; endproperty
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  property p_w_refused;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_ar_refused; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_ready_up;
    $rose(aresetn) |-> ##[1:2] s_axi_awready && s_axi_arready;
  endproperty
  property p_bresp_legal;
    s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10;
  endproperty
  property p_pin_cause;
    quiet_reg > 4'h8 |-> $stable(waveform_output_pin) &&
      $stable(waveform_output_oe);
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write got no response");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read got no response");
  a_b_once: assert property (p_b_once)
    else $error("write response repeated");
  a_r_once: assert property (p_r_once)
    else $error("read response repeated");
  a_w_refused: assert property (p_w_refused)
    else $error("write accepted while response pending");
  a_ar_refused: assert property (p_ar_refused)
    else $error("read accepted while response pending");
  a_ready_up: assert property (p_ready_up)
    else $error("bus not ready after reset");
  a_bresp_legal: assert property (p_bresp_legal)
    else $error("illegal write response code");
  a_pin_cause: assert property (p_pin_cause)
    else $error("output pin moved without tick, write or trigger");
endmodule
bind ptmr_top ptmr_checker chk_u (.aclk, .aresetn, .tick_en,
  .clock_trigger_pin, .waveform_output_pin, .waveform_output_oe,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// file: verification/ptmr_pins_model.sv
// far-side pin model: drives the two timer input pins, reads the output
// assumes the bench asks for pin levels; the output line has a pull-up
`timescale 1ns/100ps
module ptmr_pins_model (
  input wire logic cap_lvl,
  input wire logic trig_lvl,
  input wire logic waveform_output_pin,
  input wire logic waveform_output_oe,
  output logic capture_input_pin,
  output logic clock_trigger_pin,
  output logic line_lvl
);
  // pins move off the clock grid, as a real outside source would
  initial begin
    capture_input_pin = 1'b0;
    clock_trigger_pin = 1'b0;
  end
  always @(cap_lvl) capture_input_pin <= #1.3 cap_lvl;
  always @(trig_lvl) clock_trigger_pin <= #1.7 trig_lvl;
  // a released output floats up to the pull-up level
  assign line_lvl = waveform_output_oe ? waveform_output_pin : 1'b1;
endmodule

// file: verification/periodic_timer_modes_test.sv
// bench for the periodic timer: register tasks over the bus, mode tests
// assumes ptmr_top, the pin model and the bound checker are compiled
`timescale 1ns/100ps
`include "ptmr_defs.svh"
module periodic_timer_modes_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic tick_en = 1'b0;
  logic cap_lvl = 1'b0;
  logic trig_lvl = 1'b0;
  logic capture_input_pin, clock_trigger_pin, line_lvl;
  logic waveform_output_pin, waveform_output_oe;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic [31:0] s_axi_rdata, v;
  int n_fail = 0, samples_checked = 0, cyc = 0, hi;
  always #2.5 aclk = ~aclk;
  ptmr_pins_model pins_u (.cap_lvl, .trig_lvl, .waveform_output_pin,
    .waveform_output_oe, .capture_input_pin, .clock_trigger_pin, .line_lvl);
  ptmr_top dut_u (.aclk, .aresetn, .tick_en, .capture_input_pin,
    .clock_trigger_pin, .waveform_output_pin, .waveform_output_oe,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // whole run needs about 5000 cycles; a hang stops well past that
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit aw_done = 0;
    bit w_done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1;
      end
      if (!w_done && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  function automatic logic [31:0] c1(input ptmr_pkg::ptmr_mode_t m,
    input logic [1:0] p, input logic [3:0] b);
    return {24'h0, m, p, b};
  endfunction
  // reprogram only while stopped: mode and pin bits are unsafe when running
  task automatic cfg(input logic [31:0] c, input logic [9:0] d, p,
    input logic en);
    wr(`PTMR_OFF_CTRL0, 32'h0);
    wr(`PTMR_OFF_CTRL1, c);
    wr(`PTMR_OFF_DUTY, {22'h0, d});
    wr(`PTMR_OFF_PERIOD, {22'h0, p});
    wr(`PTMR_OFF_STATUS, 32'h3);
    if (en) wr(`PTMR_OFF_CTRL0, 32'h8);
  endtask
  task automatic tk(input int n);
    @(posedge aclk) tick_en <= 1'b1;
    repeat (n) @(posedge aclk);
    tick_en <= 1'b0;
  endtask
  // high cycles of the line over whole periods with ticks every cycle
  task automatic pw(input logic [31:0] c, input logic [9:0] d, p,
    input int n, e);
    cfg(c, d, p, 1'b1);
    @(posedge aclk) tick_en <= 1'b1;
    repeat (8) @(posedge aclk);
    hi = 0;
    repeat (n) begin
      @(posedge aclk);
      hi += line_lvl;
    end
    chk(hi, e);
  endtask
  // move one input pin; a hit lands between the counts read around it
  task automatic cp(input logic [31:0] c, input logic sel, lvl, hit);
    logic [31:0] a, b, s;
    cfg(c, 10'h0, 10'h0, 1'b1);
    @(posedge aclk) tick_en <= 1'b1;
    repeat (20) @(posedge aclk);
    rd(`PTMR_OFF_COUNT, a);
    if (sel) trig_lvl <= lvl;
    else cap_lvl <= lvl;
    repeat (12) @(posedge aclk);
    rd(`PTMR_OFF_COUNT, b);
    rd(`PTMR_OFF_DUTY, v);
    rd(`PTMR_OFF_STATUS, s);
    chk(s[0], hit);
    chk(hit ? (v > a && v < b) : v == 0, 1'b1);
    chk(b > a, 1'b1);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`PTMR_OFF_CTRL1, 32'h0);
    rc(`PTMR_OFF_STATUS, 32'h0);
    rd(12'h018, v);
    chk(last_resp, ptmr_pkg::PTMR_AXI_SLVERR);
    wr(12'h018, 32'h0);
    chk(last_resp, ptmr_pkg::PTMR_AXI_SLVERR);
    wr(`PTMR_OFF_PERIOD, 32'h0);
    chk(last_resp, ptmr_pkg::PTMR_AXI_OKAY);
    $display("reset test done");
    cfg(c1(ptmr_pkg::PTMR_MODE_CMP, 2'b11, 4'b0001), 10'h5, 10'h2, 1'b1);
    chk({waveform_output_oe, waveform_output_pin}, 2'b10);
    tk(6);
    rc(`PTMR_OFF_STATUS, 32'h1);
    chk(waveform_output_pin, 1'b1);
    rd(`PTMR_OFF_COUNT, v);
    chk(v <= 1, 1'b1);
    rc(`PTMR_OFF_STATUS, 32'h1);
    wr(`PTMR_OFF_STATUS, 32'h1);
    rc(`PTMR_OFF_STATUS, 32'h0);
    tk(3);
    rc(`PTMR_OFF_COUNT, 32'h3);
    wr(`PTMR_OFF_CTRL0, 32'h0);
    tk(4);
    rc(`PTMR_OFF_COUNT, 32'h3);
    wr(`PTMR_OFF_CTRL0, 32'h8);
    rc(`PTMR_OFF_COUNT, 32'h0);
    chk(waveform_output_pin, 1'b0);
    $display("compare test done");
    cfg(c1(ptmr_pkg::PTMR_MODE_TMR, 2'b11, 4'b0001), 10'h3, 10'h2, 1'b1);
    tk(5);
    chk(waveform_output_oe, 1'b0);
    rc(`PTMR_OFF_STATUS, 32'h1);
    cfg(c1(ptmr_pkg::PTMR_MODE_TMR, 2'b11, 4'b0000), 10'h3, 10'h2, 1'b1);
    tk(5);
    rc(`PTMR_OFF_STATUS, 32'h2);
    $display("timer test done");
    pw(c1(ptmr_pkg::PTMR_MODE_PWM, 2'b10, 4'b1000), 2, 4, 40, 20);
    rc(`PTMR_OFF_STATUS, 32'h3);
    pw(c1(ptmr_pkg::PTMR_MODE_PWM, 2'b10, 4'b1001), 1, 4, 40, 10);
    pw(c1(ptmr_pkg::PTMR_MODE_PWM, 2'b10, 4'b1100), 1, 4, 40, 30);
    pw(c1(ptmr_pkg::PTMR_MODE_PWM, 2'b10, 4'b0000), 1, 4, 40, 30);
    pw(c1(ptmr_pkg::PTMR_MODE_PWM, 2'b10, 4'b0100), 1, 4, 40, 10);
    pw(c1(ptmr_pkg::PTMR_MODE_PWM, 2'b10, 4'b1000), 4, 4, 40, 40);
    pw(c1(ptmr_pkg::PTMR_MODE_PWM, 2'b10, 4'b1000), 9, 4, 40, 40);
    pw(c1(ptmr_pkg::PTMR_MODE_PWM, 2'b00, 4'b1000), 2, 4, 40, 0);
    rc(`PTMR_OFF_STATUS, 32'h3);
    pw(c1(ptmr_pkg::PTMR_MODE_PWM, 2'b01, 4'b1000), 2, 4, 40, 40);
    pw(c1(ptmr_pkg::PTMR_MODE_PWM, 2'b10, 4'b1000), 256, 0, 2048, 512);
    $display("pwm test done");
    cfg(c1(ptmr_pkg::PTMR_MODE_PWM, 2'b11, 4'b1000), 10'h6, 10'h2, 0);
    trig_lvl <= 1'b1;
    hi = 0;
    repeat (40) begin
      @(posedge aclk);
      hi += line_lvl;
    end
    chk(hi >= 6 && hi <= 8, 1'b1);
    rd(`PTMR_OFF_CTRL0, v);
    chk(v[3], 1'b0);
    rd(`PTMR_OFF_STATUS, v);
    chk(v[0], 1'b1);
    trig_lvl <= 1'b0;
    tick_en <= 1'b0;
    // the pin register follows the enable one edge later
    wr(`PTMR_OFF_CTRL0, 32'h8);
    @(posedge aclk);
    chk(waveform_output_pin, 1'b1);
    wr(`PTMR_OFF_CTRL0, 32'h0);
    @(posedge aclk);
    chk(waveform_output_pin, 1'b0);
    $display("pulse test done");
    cp(c1(ptmr_pkg::PTMR_MODE_CAP, 2'b00, 4'b0000), 0, 1, 1);
    cp(c1(ptmr_pkg::PTMR_MODE_CAP, 2'b01, 4'b0000), 0, 0, 1);
    cp(c1(ptmr_pkg::PTMR_MODE_CAP, 2'b10, 4'b0010), 1, 1, 1);
    cp(c1(ptmr_pkg::PTMR_MODE_CAP, 2'b00, 4'b0010), 1, 0, 0);
    cp(c1(ptmr_pkg::PTMR_MODE_CAP, 2'b11, 4'b0000), 0, 1, 0);
    cp(c1(ptmr_pkg::PTMR_MODE_CAP, 2'b10, 4'b0010), 0, 0, 0);
    tick_en <= 1'b0;
    cfg(c1(ptmr_pkg::PTMR_MODE_CAP, 2'b11, 4'b0000), 10'h0, 10'h5, 1'b1);
    tk(20);
    rd(`PTMR_OFF_COUNT, v);
    chk(v <= 5, 1'b1);
    rd(`PTMR_OFF_STATUS, v);
    chk(v[1], 1'b1);
    cfg(c1(ptmr_pkg::PTMR_MODE_CAP, 2'b11, 4'b0000), 10'h0, 10'h0, 1'b1);
    tk(1030);
    rd(`PTMR_OFF_COUNT, v);
    chk(v >= 5 && v <= 7, 1'b1);
    $display("capture test done");
    tally_and_finish();
  end
endmodule
